// ==== inc/bcs_pkg.sv ====
// Constants and types shared by the branch and call sequencer.
package bcs_pkg;

  localparam int PC_W    = 11;
  localparam int PAGE_W  = 4;
  localparam int LOW_W   = 7;
  localparam int WORD_W  = 9;
  localparam int FIELD_W = 3;
  localparam int ACC_W   = 4;

  // Field positions inside a 9-bit instruction word.
  localparam int CLS_HI   = 8;
  localparam int CLS_LO   = 7;
  localparam int X_HI     = 6;
  localparam int X_LO     = 4;
  localparam int Y_HI     = 3;
  localparam int Y_LO     = 0;
  localparam int OPH_HI   = 8;
  localparam int OPH_LO   = 4;

  // Instruction encodings.
  localparam logic [WORD_W-1:0] WORD_PREFIX   = 9'h001;
  localparam logic [WORD_W-1:0] WORD_RET      = 9'h044;
  localparam logic [WORD_W-1:0] WORD_RET_SKIP = 9'h045;
  localparam logic [4:0]        OPH_PAGE_WORD = 5'h07;
  localparam logic [1:0]        CLS_JUMP      = 2'h3;
  localparam logic [1:0]        CLS_CALL      = 2'h2;

  // Fixed pages and reset values.
  localparam logic [PAGE_W-1:0] PAGE_JUMP_SPECIAL = 4'hF;
  localparam logic [PAGE_W-1:0] PAGE_CALL_SHORT   = 4'hE;
  localparam logic [PAGE_W-1:0] PAGE_INT_ENTRY    = 4'hC;
  localparam logic [LOW_W-1:0]  LOW_INT_ENTRY     = 7'h00;
  localparam logic [PC_W-1:0]   PC_RESET          = 11'h000;
  localparam logic [WORD_W-1:0] WORD_RESET        = 9'h000;
  localparam logic [PAGE_W-1:0] PAGE_RESET        = 4'h0;

  typedef enum logic [1:0] {
    BCS_ST_NORM = 2'b01,
    BCS_ST_PAGE = 2'b10
  } bcs_state_t;

endpackage

// ==== design/bcs_ret_stack.sv ====
// Three-level return address stack of the branch and call sequencer.
`timescale 1ns/1ps
module bcs_ret_stack #(
  parameter int W = 11
) (
  // Clock and reset.
  input  wire logic         core_clk,
  input  wire logic         resetn,
  // Push and pop requests.
  input  wire logic         push,
  input  wire logic         pop,
  input  wire logic [W-1:0] push_val,
  // Stack levels.
  output logic      [W-1:0] stack_level_zero,
  output logic      [W-1:0] stack_level_one,
  output logic      [W-1:0] stack_level_two
);
  import bcs_pkg::*;

  // Level two keeps its value on a pop, so a deep return repeats the oldest address.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      stack_level_zero <= W'(PC_RESET);
      stack_level_one  <= W'(PC_RESET);
      stack_level_two  <= W'(PC_RESET);
    end else if (push) begin
      stack_level_two  <= stack_level_one;
      stack_level_one  <= stack_level_zero;
      stack_level_zero <= push_val;
    end else if (pop) begin
      stack_level_zero <= stack_level_one;
      stack_level_one  <= stack_level_two;
    end
  end

endmodule

// ==== design/bcs_sequencer.sv ====
// Program flow sequencer: jump and call decode, paged program counter, return stack.
`timescale 1ns/1ps
module bcs_sequencer
  import bcs_pkg::*;
(
  // Clock and reset.
  input  wire logic                        core_clk,
  input  wire logic                        resetn,
  // Program memory.
  input  wire logic [bcs_pkg::WORD_W-1:0]  rom_data,
  output logic      [bcs_pkg::PC_W-1:0]    prog_addr,
  // Core data path.
  input  wire logic [bcs_pkg::ACC_W-1:0]   acc_val,
  // Interrupt entry.
  input  wire logic                        irq_pending,
  output logic                             int_taken,
  // Execution status.
  output logic      [bcs_pkg::WORD_W-1:0]  exec_word,
  output logic                             exec_valid,
  output logic                             index_flag,
  output logic                             special_page,
  // Return stack.
  output logic      [bcs_pkg::PC_W-1:0]    stack_level_zero,
  output logic      [bcs_pkg::PC_W-1:0]    stack_level_one,
  output logic      [bcs_pkg::PC_W-1:0]    stack_level_two
);
  import bcs_pkg::*;

  // In-page target: x field in the high bits, y field or accumulator below.
  function automatic logic [LOW_W-1:0] inpage_target(
    input logic [WORD_W-1:0] word,
    input logic              use_acc,
    input logic [ACC_W-1:0]  acc
  );
    logic [ACC_W-1:0] low_nib;
    low_nib = use_acc ? acc : word[Y_HI:Y_LO];
    return {word[X_HI:X_LO], low_nib};
  endfunction

  // Sequential step inside the current page.
  function automatic logic [PC_W-1:0] next_seq(input logic [PC_W-1:0] pc);
    logic [LOW_W-1:0] low_inc;
    low_inc = pc[LOW_W-1:0] + 7'h01;
    return {pc[PC_W-1:LOW_W], low_inc};
  endfunction

  logic [PC_W-1:0]   pc_r;
  logic [PC_W-1:0]   pc_nxt;
  logic [WORD_W-1:0] ir_r;
  logic              ir_valid_r;
  logic              squash;
  bcs_state_t        state_r;
  bcs_state_t        state_nxt;
  logic [PAGE_W-1:0] page_hold_r;
  logic [PAGE_W-1:0] page_hold_nxt;
  logic              idx_r;
  logic              idx_nxt;
  logic              special_r;
  logic              special_nxt;
  logic              push;
  logic              pop;
  logic              int_take;
  logic              int_taken_r;

  logic [1:0]        ir_cls;
  logic              is_prefix;
  logic              is_page_word;
  logic              is_return;
  logic              is_branch;
  logic [LOW_W-1:0]  tgt_low;

  assign ir_cls       = ir_r[CLS_HI:CLS_LO];
  assign is_prefix    = (ir_r == WORD_PREFIX);
  assign is_page_word = (ir_r[OPH_HI:OPH_LO] == OPH_PAGE_WORD);
  assign is_return    = (ir_r == WORD_RET) || (ir_r == WORD_RET_SKIP);
  assign is_branch    = (ir_cls == CLS_JUMP) || (ir_cls == CLS_CALL);
  assign tgt_low      = inpage_target(ir_r, idx_r, acc_val);

  // Decode of the word in execution and the address for the next fetch.
  always_comb begin
    pc_nxt        = next_seq(pc_r);
    state_nxt     = state_r;
    page_hold_nxt = page_hold_r;
    idx_nxt       = idx_r;
    special_nxt   = special_r;
    push          = 1'b0;
    pop           = 1'b0;
    squash        = 1'b0;
    int_take      = 1'b0;
    if (ir_valid_r) begin
      case (state_r)
        BCS_ST_PAGE: begin
          // Last word of a long jump or long call.
          state_nxt   = BCS_ST_NORM;
          idx_nxt     = 1'b0;
          special_nxt = 1'b0;
          squash      = 1'b1;
          pc_nxt      = {page_hold_r, tgt_low};
          if (ir_cls == CLS_CALL) begin
            push = 1'b1;
          end
        end
        BCS_ST_NORM: begin
          if (is_prefix) begin
            idx_nxt = 1'b1;
          end else if (is_page_word) begin
            page_hold_nxt = ir_r[PAGE_W-1:0];
            state_nxt     = BCS_ST_PAGE;
          end else if (ir_cls == CLS_JUMP) begin
            idx_nxt = 1'b0;
            squash  = 1'b1;
            if (special_r) begin
              pc_nxt = {PAGE_JUMP_SPECIAL, tgt_low};
            end else begin
              pc_nxt = {pc_r[PC_W-1:LOW_W], tgt_low};
            end
          end else if (ir_cls == CLS_CALL) begin
            idx_nxt     = 1'b0;
            squash      = 1'b1;
            push        = 1'b1;
            special_nxt = 1'b1;
            pc_nxt      = {PAGE_CALL_SHORT, tgt_low};
          end else if (is_return) begin
            idx_nxt     = 1'b0;
            squash      = 1'b1;
            pop         = 1'b1;
            special_nxt = 1'b0;
            pc_nxt      = stack_level_zero;
          end else begin
            idx_nxt = 1'b0;
          end
        end
        default: begin
          state_nxt = BCS_ST_NORM;
          idx_nxt   = 1'b0;
        end
      endcase
    end
    // An interrupt never splits a multi-word instruction, a jump or a call; a return can be interrupted.
    if (irq_pending && (state_nxt == BCS_ST_NORM) && !idx_nxt
        && !(ir_valid_r && is_branch)) begin
      // The fetched word is dropped and its address saved unincremented.
      int_take = 1'b1;
      push     = 1'b1;
      squash   = 1'b1;
      pc_nxt   = {PAGE_INT_ENTRY, LOW_INT_ENTRY};
    end
  end

  // Program counter, also the fetch address.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pc_r <= PC_RESET;
    end else begin
      pc_r <= pc_nxt;
    end
  end

  // Fetched word, executed one cycle later; a taken branch discards it.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ir_r       <= WORD_RESET;
      ir_valid_r <= 1'b0;
    end else begin
      ir_r       <= rom_data;
      ir_valid_r <= !squash;
    end
  end

  // Multi-word sequencing and the accumulator index flag.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_r     <= BCS_ST_NORM;
      page_hold_r <= PAGE_RESET;
      idx_r       <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      page_hold_r <= page_hold_nxt;
      idx_r       <= idx_nxt;
    end
  end

  // Special page flag: set by short calls, cleared by returns and long forms.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      special_r <= 1'b0;
    end else begin
      special_r <= special_nxt;
    end
  end

  // Interrupt entry pulse.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      int_taken_r <= 1'b0;
    end else begin
      int_taken_r <= int_take;
    end
  end

  bcs_ret_stack #(
    .W (PC_W)
  ) u_stack (
    .core_clk         (core_clk),
    .resetn           (resetn),
    .push             (push),
    .pop              (pop),
    .push_val         (pc_r),
    .stack_level_zero (stack_level_zero),
    .stack_level_one  (stack_level_one),
    .stack_level_two  (stack_level_two)
  );

  assign prog_addr    = pc_r;
  assign exec_word    = ir_r;
  assign exec_valid   = ir_valid_r;
  assign index_flag   = idx_r;
  assign special_page = special_r;
  assign int_taken    = int_taken_r;

endmodule

// ==== dv/bcs_sequencer_checker.sv ====
// Port-level assertions for the branch and call sequencer.
`timescale 1ns/1ps
module bcs_sequencer_checker
  import bcs_pkg::*;
(
  // Clock and reset.
  input wire logic                       core_clk,
  input wire logic                       resetn,
  // Observed ports.
  input wire logic [bcs_pkg::PC_W-1:0]   prog_addr,
  input wire logic [bcs_pkg::ACC_W-1:0]  acc_val,
  input wire logic                       irq_pending,
  input wire logic                       int_taken,
  input wire logic [bcs_pkg::WORD_W-1:0] exec_word,
  input wire logic                       exec_valid,
  input wire logic                       index_flag,
  input wire logic                       special_page,
  input wire logic [bcs_pkg::PC_W-1:0]   stack_level_zero,
  input wire logic [bcs_pkg::PC_W-1:0]   stack_level_one,
  input wire logic [bcs_pkg::PC_W-1:0]   stack_level_two
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_reset_clears_pc: assert property ($rose(resetn) |-> prog_addr == PC_RESET && !special_page
    && stack_level_zero == PC_RESET) else $error("state not cleared by reset");
  // Interrupt entry is excluded here because it deliberately skips the increment.
  a_step_in_page: assert property (exec_valid && !exec_word[CLS_HI] && exec_word != WORD_RET
    && exec_word != WORD_RET_SKIP && !irq_pending |=> prog_addr == {$past(prog_addr[10:7]),
    $past(prog_addr[6:0]) + 7'h01}) else $error("fetch address did not step in page");
  a_jump_in_page: assert property (exec_valid && exec_word[8:7] == CLS_JUMP && !index_flag
    && !special_page && $past(exec_word[8:4]) != OPH_PAGE_WORD |=> prog_addr ==
    {$past(prog_addr[10:7]), $past(exec_word[6:0])}) else $error("in-page jump target wrong");
  a_jump_special: assert property (exec_valid && exec_word[8:7] == CLS_JUMP && special_page
    && $past(exec_word[8:4]) != OPH_PAGE_WORD |=> prog_addr[10:7] == PAGE_JUMP_SPECIAL)
    else $error("jump after short call missed page fifteen");
  a_index_low: assert property (exec_valid && index_flag && exec_word[CLS_HI] |=>
    prog_addr[6:0] == {$past(exec_word[6:4]), $past(acc_val)}) else $error("indexed low part wrong");
  a_call_short: assert property (exec_valid && exec_word[8:7] == CLS_CALL
    && $past(exec_word[8:4]) != OPH_PAGE_WORD |=> prog_addr[10:7] == PAGE_CALL_SHORT
    && special_page && stack_level_zero == $past(prog_addr)) else $error("short call wrong");
  a_call_push: assert property (exec_valid && exec_word[8:7] == CLS_CALL |=>
    stack_level_one == $past(stack_level_zero) && stack_level_two == $past(stack_level_one))
    else $error("call did not push the stack");
  a_return_pop: assert property (exec_valid && exec_word == WORD_RET && !irq_pending |=>
    prog_addr == $past(stack_level_zero) && stack_level_zero == $past(stack_level_one)
    && stack_level_one == $past(stack_level_two) && !special_page) else $error("return pop wrong");
  a_int_entry: assert property (int_taken |-> prog_addr == {PAGE_INT_ENTRY, LOW_INT_ENTRY}
    && stack_level_zero == $past(prog_addr) ##1 !int_taken) else $error("interrupt entry wrong");

  c_interrupt: cover property (int_taken);
  c_return: cover property (exec_valid && exec_word == WORD_RET);
  c_special_index: cover property (special_page && index_flag && exec_valid && exec_word[CLS_HI]);
endmodule

bind bcs_sequencer bcs_sequencer_checker i_bcs_sequencer_checker (.core_clk, .resetn, .prog_addr,
  .acc_val, .irq_pending, .int_taken, .exec_word, .exec_valid, .index_flag, .special_page,
  .stack_level_zero, .stack_level_one, .stack_level_two);

// ==== dv/bcs_sequencer_tb.sv ====
// Self-checking bench for the branch and call sequencer.
`timescale 1ns/1ps
module bcs_sequencer_tb;
  import bcs_pkg::*;
  typedef struct packed {
    logic [WORD_W-1:0] w0, w1, w2;
    logic [1:0]        nw;
    logic [ACC_W-1:0]  acc;
    logic [PC_W-1:0]   addr, lvl0;
    logic              sp;
  } bcs_row_t;

  logic              core_clk    = 1'b0;
  logic              resetn      = 1'b0;
  logic              irq_pending = 1'b0;
  logic [ACC_W-1:0]  acc_val     = 4'h0;
  logic [WORD_W-1:0] rom_data    = 9'h000;
  logic [WORD_W-1:0] exec_word;
  logic [WORD_W-1:0] rom [2048];
  logic [PC_W-1:0]   prog_addr, stack_level_zero, stack_level_one, stack_level_two;
  logic              int_taken, exec_valid, index_flag, special_page;
  int                miscompares = 0, n_compared = 0, cycles = 0;

  // Words, word count, accumulator, target, level zero, special flag.
  bcs_row_t rows [8] = '{
    '{9'h1DA, 9'h000, 9'h000, 2'h1, 4'h0, 11'h05A, 11'h000, 1'b0},
    '{9'h073, 9'h1A7, 9'h000, 2'h2, 4'h0, 11'h1A7, 11'h000, 1'b0},
    '{9'h001, 9'h1E0, 9'h000, 2'h2, 4'h9, 11'h069, 11'h000, 1'b0},
    '{9'h001, 9'h075, 9'h190, 2'h3, 4'hC, 11'h29C, 11'h000, 1'b0},
    '{9'h134, 9'h000, 9'h000, 2'h1, 4'h0, 11'h734, 11'h001, 1'b1},
    '{9'h072, 9'h17F, 9'h000, 2'h2, 4'h0, 11'h17F, 11'h002, 1'b0},
    '{9'h001, 9'h079, 9'h140, 2'h3, 4'hF, 11'h4CF, 11'h003, 1'b0},
    '{9'h001, 9'h100, 9'h000, 2'h2, 4'h3, 11'h703, 11'h002, 1'b1}
  };

  bcs_sequencer i_bcs_sequencer (.core_clk, .resetn, .rom_data, .prog_addr, .acc_val,
    .irq_pending, .int_taken, .exec_word, .exec_valid, .index_flag, .special_page,
    .stack_level_zero, .stack_level_one, .stack_level_two);

  always #2.5 core_clk = ~core_clk;

  // The program memory answers one small delay after the address settles.
  always @(posedge core_clk) begin
    #1 rom_data = rom[prog_addr];
  end

  task automatic end_of_test();
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic check(input logic [PC_W-1:0] seen, input logic [PC_W-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic rst_on();
    @(posedge core_clk);
    #1 resetn = 1'b0;
    foreach (rom[i]) rom[i] = WORD_RESET;
  endtask

  task automatic go(input int n);
    repeat (n) @(posedge core_clk);
    #1 resetn = 1'b1;
  endtask

  // One fetch edge per word, then one edge for the branch to land.
  task automatic step(input int nw, input logic [PC_W-1:0] exp);
    repeat (nw + 1) @(posedge core_clk);
    #2 check(prog_addr, exp);
  endtask

  initial begin
    rst_on();
    go(5);
    foreach (rows[i]) begin
      rst_on();
      {rom[0], rom[1], rom[2]} = {rows[i].w0, rows[i].w1, rows[i].w2};
      acc_val = rows[i].acc;
      go(1);
      step(rows[i].nw, rows[i].addr);
      check(stack_level_zero, rows[i].lvl0);
      check(special_page, rows[i].sp);
      check(exec_valid, 1'b0);
      check(index_flag, 1'b0);
    end
    rst_on();
    @(posedge core_clk);
    #2 check(prog_addr, PC_RESET);
    check(special_page, 1'b0);
    check(stack_level_zero, PC_RESET);
    rom[11'h000] = 9'h134;
    rom[11'h734] = 9'h1DA;
    rom[11'h7DA] = 9'h001;
    rom[11'h7DB] = 9'h1E0;
    rom[11'h7E9] = 9'h120;
    rom[11'h720] = 9'h001;
    rom[11'h721] = 9'h100;
    rom[11'h709] = WORD_RET;
    rom[11'h722] = 9'h1DA;
    rom[11'h75A] = WORD_RET_SKIP;
    go(1);
    acc_val = 4'h9;
    step(1, 11'h734);
    step(1, 11'h7DA);
    step(2, 11'h7E9);
    step(1, 11'h720);
    step(2, 11'h709);
    check(stack_level_zero, 11'h722);
    check(stack_level_one, 11'h7EA);
    check(stack_level_two, 11'h001);
    step(1, 11'h722);
    check(stack_level_zero, 11'h7EA);
    check(stack_level_one, 11'h001);
    check(special_page, 1'b0);
    step(1, 11'h75A);
    step(1, 11'h7EA);
    check(stack_level_zero, 11'h001);
    rst_on();
    go(1);
    rom[2] = 9'h0A5;
    repeat (3) @(posedge core_clk);
    #1 irq_pending = 1'b1;
    check(exec_word, 9'h0A5);
    check(exec_valid, 1'b1);
    @(posedge core_clk);
    #1 irq_pending = 1'b0;
    #1 check(prog_addr, {PAGE_INT_ENTRY, LOW_INT_ENTRY});
    check(stack_level_zero, 11'h003);
    check(int_taken, 1'b1);
    check(exec_valid, 1'b0);
    end_of_test();
  end
endmodule
